//--- logic/tcdf_pkg.sv
// constants, register map and types of the trace clock demux front end
package tcdf_pkg;
  localparam int unsigned NUM_LINES = 5;
  localparam int unsigned POD_W     = 16;
  localparam int unsigned NUM_PODS  = 2;
  localparam int unsigned CH_W      = POD_W * NUM_PODS;
  localparam int unsigned HALF_W    = 8;
  // clock line indices: two external, three internal
  localparam int unsigned LINE_EXT_A  = 0;
  localparam int unsigned LINE_EXT_B  = 1;
  localparam int unsigned LINE_EMUL   = 2;
  localparam int unsigned LINE_SPARE  = 3;
  localparam int unsigned LINE_FGBG   = 4;
  // edge select codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // slave mode codes
  localparam logic [1:0] SLV_OFF   = 2'h0;
  localparam logic [1:0] SLV_MIXED = 2'h1;
  localparam logic [1:0] SLV_DEMUX = 2'h2;
  // speed grades
  localparam logic [1:0] SPD_SLOW = 2'h0;
  localparam logic [1:0] SPD_FAST = 2'h1;
  localparam logic [1:0] SPD_HIGH = 2'h2;
  // clock period and qualified rate limits
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  localparam int unsigned RATE_SLOW_KHZ   = 16000;
  localparam int unsigned RATE_FAST_KHZ   = 20000;
  localparam int unsigned RATE_HIGH_KHZ   = 25000;
  localparam int unsigned GAP_SLOW = (1000000000 / RATE_SLOW_KHZ + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;
  localparam int unsigned GAP_FAST = (1000000000 / RATE_FAST_KHZ + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;
  localparam int unsigned GAP_HIGH = (1000000000 / RATE_HIGH_KHZ + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;
  localparam int unsigned GAP_W = 4;
  // count qualifier modes
  localparam logic [1:0] CQ_ANY   = 2'h0;
  localparam logic [1:0] CQ_STATE = 2'h1;
  localparam logic [1:0] CQ_NONE  = 2'h2;
  // activity codes per channel
  localparam logic [1:0] ACT_LOW  = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_MOVE = 2'h2;
  localparam logic [7:0] ACT_WIN  = 8'hff;
  // register byte addresses
  localparam logic [7:0] ADDR_MEDGE   = 8'h00;
  localparam logic [7:0] ADDR_QUAL    = 8'h04;
  localparam logic [7:0] ADDR_SPEED   = 8'h08;
  localparam logic [7:0] ADDR_SLAVE   = 8'h0c;
  localparam logic [7:0] ADDR_SAMPLE  = 8'h10;
  localparam logic [7:0] ADDR_LIVE    = 8'h14;
  localparam logic [7:0] ADDR_ACT_LO  = 8'h18;
  localparam logic [7:0] ADDR_ACT_HI  = 8'h1c;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;
  // reset values: rising edge of emulation clock, foreground only, slow, slaves off
  localparam logic [9:0] RST_MEDGE = 10'h010;
  localparam logic [1:0] RST_FGBG  = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TCDF_WR_IDLE = 3'b001,
    TCDF_WR_RESP = 3'b010,
    TCDF_WR_HOLD = 3'b100
  } tcdf_wr_e;

  typedef struct packed {
    logic [NUM_LINES-1:0] ln_s1;
    logic [NUM_LINES-1:0] ln_s2;
    logic [NUM_LINES-1:0] ln_d;
    logic [CH_W-1:0]      ch_s1;
    logic [CH_W-1:0]      ch_s2;
    logic [CH_W-1:0]      ch_d;
    logic [CH_W-1:0]      moved;
    logic [CH_W-1:0]      act_move;
    logic [7:0]           act_cnt;
    logic [9:0]           medge;
    logic [4:0]           qual_lo;
    logic [4:0]           qual_hi;
    logic [1:0]           fgbg;
    logic [1:0]           speed;
    logic [1:0]           slv_mode0;
    logic [1:0]           slv_mode1;
    logic [9:0]           slv_edge0;
    logic [9:0]           slv_edge1;
    logic [HALF_W-1:0]    slv_lat0;
    logic [HALF_W-1:0]    slv_lat1;
    logic                 slv_got0;
    logic                 slv_got1;
    logic [GAP_W-1:0]     gap;
    logic [CH_W-1:0]      sample;
    logic                 sample_valid;
    logic [15:0]          dropped;
    tcdf_wr_e             wst;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } tcdf_state_s;
endpackage

//--- logic/tcdf_frontend.sv
// sampling front end: master clock select, qualifiers, rate cap, slave demux, activity
//
// How it works
// - each channel shows low, high or moving
// - pod one holds channels 0-15, pod two 16-31
// - live state sampled always, trace or not
// - foreground by default; background or both selectable
// - qualifier field independent of other clock fields
// - per line rising, falling or both edges
// - five lines: two external, three internal
// - internal lines: emulation clock, qualifier, spare
// - selected edges are ORed together
// - three rate caps: slow, fast, highest
// - count qualifier any, states only, or none
// - qualifier lines gate on low or high level
// - any true qualifier lets the clock through
// - slave off by default; per pod edge select
// - mixed: low byte slave-latched, master captures pod
// - mixed: no slave edge, low byte live
// - only first slave edge kept per master interval
// - demux: upper byte from the pod's lowest eight channels (0-7, 16-23) at master
// - demux: no slave edge, low equals upper
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tcdf_frontend
  import tcdf_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic [NUM_LINES-1:0] clk_line,
  input  wire logic [CH_W-1:0]      trace_ch,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [CH_W-1:0]           sample_data,
  output logic                      sample_valid,
  output logic [1:0]                count_qual_mode
);
  tcdf_state_s r;
  tcdf_state_s next_r;

  logic [NUM_LINES-1:0] rise;
  logic [NUM_LINES-1:0] fall;
  logic [NUM_LINES-1:0] edge_hit;
  logic [NUM_LINES-1:0] slv_hit0;
  logic [NUM_LINES-1:0] slv_hit1;
  logic [NUM_LINES-1:0] qual_ok;
  logic [2*CH_W-1:0]    act_vec;
  logic [GAP_W-1:0]     gap_need;

  // per line edge detect, edge select and level qualification
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      assign rise[g] = r.ln_s2[g] & ~r.ln_d[g];
      assign fall[g] = ~r.ln_s2[g] & r.ln_d[g];
      assign edge_hit[g] = (r.medge[2*g+1 -: 2] == EDGE_RISE && rise[g]) ||
                           (r.medge[2*g+1 -: 2] == EDGE_FALL && fall[g]) ||
                           (r.medge[2*g+1 -: 2] == EDGE_BOTH && (rise[g] | fall[g]));
      assign slv_hit0[g] = (r.slv_edge0[2*g+1 -: 2] == EDGE_RISE && rise[g]) ||
                           (r.slv_edge0[2*g+1 -: 2] == EDGE_FALL && fall[g]) ||
                           (r.slv_edge0[2*g+1 -: 2] == EDGE_BOTH && (rise[g] | fall[g]));
      assign slv_hit1[g] = (r.slv_edge1[2*g+1 -: 2] == EDGE_RISE && rise[g]) ||
                           (r.slv_edge1[2*g+1 -: 2] == EDGE_FALL && fall[g]) ||
                           (r.slv_edge1[2*g+1 -: 2] == EDGE_BOTH && (rise[g] | fall[g]));
      assign qual_ok[g] = (r.qual_lo[g] & ~r.ln_s2[g]) | (r.qual_hi[g] & r.ln_s2[g]);
    end
    for (g = 0; g < CH_W; g++) begin : g_act
      assign act_vec[2*g+1 -: 2] = r.act_move[g] ? ACT_MOVE :
                                   (r.ch_s2[g] ? ACT_HIGH : ACT_LOW);
    end
  endgenerate

  // fg/bg selection gates on the level of the internal qualifier line
  logic fgbg_any;
  logic fgbg_ok;
  logic qual_any;
  logic master_raw;
  logic master;
  logic [HALF_W-1:0] lo0;
  logic [HALF_W-1:0] lo1;
  logic [HALF_W-1:0] up0;
  logic [HALF_W-1:0] up1;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [31:0] wd;

  always_comb begin
    // bit0 foreground (line low), bit1 background (line high)
    fgbg_any = |r.fgbg;
    fgbg_ok  = (r.fgbg[0] & ~r.ln_s2[LINE_FGBG]) | (r.fgbg[1] & r.ln_s2[LINE_FGBG]);
    qual_any = fgbg_any | (|r.qual_lo) | (|r.qual_hi);
    master_raw = (|edge_hit) && (!qual_any || fgbg_ok || (|qual_ok));
    case (r.speed)
      SPD_FAST: gap_need = GAP_W'(GAP_FAST);
      SPD_HIGH: gap_need = GAP_W'(GAP_HIGH);
      default:  gap_need = GAP_W'(GAP_SLOW);
    endcase
    master = master_raw && (r.gap == '0);
    // low byte per pod: first slave latch, else live
    lo0 = r.slv_got0 ? r.slv_lat0 : r.ch_s2[HALF_W-1:0];
    lo1 = r.slv_got1 ? r.slv_lat1 : r.ch_s2[POD_W+HALF_W-1:POD_W];
    up0 = (r.slv_mode0 == SLV_DEMUX) ? r.ch_s2[HALF_W-1:0] : r.ch_s2[POD_W-1:HALF_W];
    up1 = (r.slv_mode1 == SLV_DEMUX) ? r.ch_s2[POD_W+HALF_W-1:POD_W] :
                                       r.ch_s2[CH_W-1:POD_W+HALF_W];
    if (r.slv_mode0 == SLV_OFF) lo0 = r.ch_s2[HALF_W-1:0];
    if (r.slv_mode1 == SLV_OFF) lo1 = r.ch_s2[POD_W+HALF_W-1:POD_W];
    if (r.slv_mode0 == SLV_DEMUX && !r.slv_got0) lo0 = up0;
    if (r.slv_mode1 == SLV_DEMUX && !r.slv_got1) lo1 = up1;

    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_MEDGE:  rd_val = {22'h0, r.medge};
      ADDR_QUAL:   rd_val = {20'h0, r.fgbg, r.qual_hi, r.qual_lo};
      ADDR_SPEED:  rd_val = {30'h0, r.speed};
      ADDR_SLAVE:  rd_val = {8'h0, r.slv_edge1, r.slv_mode1, r.slv_edge0, r.slv_mode0};
      ADDR_SAMPLE: rd_val = r.sample;
      ADDR_LIVE:   rd_val = r.ch_s2;
      ADDR_ACT_LO: rd_val = act_vec[31:0];
      ADDR_ACT_HI: rd_val = act_vec[63:32];
      ADDR_STATUS: rd_val = {11'h0, r.ln_s2, r.dropped};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    wd = s_axi_wdata;
  end

  logic wr_go;
  assign wr_go = (r.wst == TCDF_WR_IDLE) && s_axi_awvalid && s_axi_wvalid;

  always_comb begin
    next_r = r;
    // two-flop synchronisers
    next_r.ln_s1 = clk_line;
    next_r.ln_s2 = r.ln_s1;
    next_r.ln_d  = r.ln_s2;
    next_r.ch_s1 = trace_ch;
    next_r.ch_s2 = r.ch_s1;
    next_r.ch_d  = r.ch_s2;
    // activity window: moving if toggled within the last window
    next_r.moved = r.moved | (r.ch_s2 ^ r.ch_d);
    next_r.act_cnt = r.act_cnt + 8'h01;
    if (r.act_cnt == ACT_WIN) begin
      next_r.act_move = r.moved | (r.ch_s2 ^ r.ch_d);
      next_r.moved = '0;
      next_r.act_cnt = 8'h00;
    end
    // rate cap: spacing between qualified clocks
    if (r.gap != '0) next_r.gap = r.gap - GAP_W'(1);
    if (master) next_r.gap = gap_need - GAP_W'(1);
    if (master_raw && !master) next_r.dropped = r.dropped + 16'h0001;
    // capture first, so a slave edge in the same cycle opens the next interval, unless this interval already latched one
    next_r.sample_valid = master;
    if (master) begin
      next_r.sample = {up1, lo1, up0, lo0};
      next_r.slv_got0 = 1'b0;
      next_r.slv_got1 = 1'b0;
    end
    // slave latches: first edge only per master interval
    if (r.slv_mode0 != SLV_OFF && |slv_hit0 && !r.slv_got0) begin
      next_r.slv_lat0 = r.ch_s2[HALF_W-1:0];
      next_r.slv_got0 = 1'b1;
    end
    if (r.slv_mode1 != SLV_OFF && |slv_hit1 && !r.slv_got1) begin
      next_r.slv_lat1 = r.ch_s2[POD_W+HALF_W-1:POD_W];
      next_r.slv_got1 = 1'b1;
    end
    // write channel
    case (r.wst)
      TCDF_WR_IDLE: begin
        if (wr_go) begin
          next_r.wst = TCDF_WR_HOLD;
          next_r.bresp = RESP_OKAY;
          case (s_axi_awaddr)
            ADDR_MEDGE: next_r.medge = wd[9:0];
            ADDR_QUAL: begin
              next_r.qual_lo = wd[4:0];
              next_r.qual_hi = wd[9:5];
              next_r.fgbg = wd[11:10];
            end
            ADDR_SPEED: next_r.speed = (wd[1:0] == 2'h3) ? SPD_HIGH : wd[1:0];
            ADDR_SLAVE: begin
              next_r.slv_mode0 = wd[1:0];
              next_r.slv_edge0 = wd[11:2];
              next_r.slv_mode1 = wd[13:12];
              next_r.slv_edge1 = wd[23:14];
            end
            ADDR_SAMPLE, ADDR_LIVE, ADDR_ACT_LO, ADDR_ACT_HI, ADDR_STATUS: begin
              next_r.bresp = RESP_SLVERR;
            end
            default: next_r.bresp = RESP_SLVERR;
          endcase
        end
      end
      TCDF_WR_RESP: begin
        if (s_axi_bready) begin
          next_r.bvalid = 1'b0;
          next_r.wst = TCDF_WR_IDLE;
        end
      end
      // response only after address and data were taken
      TCDF_WR_HOLD: begin
        next_r.bvalid = 1'b1;
        next_r.wst = TCDF_WR_RESP;
      end
      default: next_r.wst = TCDF_WR_IDLE;
    endcase
    // read channel
    next_r.arready = 1'b0;
    if (r.rvalid) begin
      if (s_axi_rready) next_r.rvalid = 1'b0;
    end else if (r.arready) begin
      next_r.rvalid = 1'b1;
    end else if (s_axi_arvalid) begin
      next_r.arready = 1'b1;
      next_r.rdata = rd_val;
      next_r.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.medge <= RST_MEDGE;
      r.fgbg <= RST_FGBG;
      r.speed <= SPD_SLOW;
      r.slv_mode0 <= SLV_OFF;
      r.slv_mode1 <= SLV_OFF;
      r.wst <= TCDF_WR_IDLE;
    end else begin
      r <= next_r;
    end
  end

  logic awready_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) awready_q <= 1'b0;
    else awready_q <= wr_go;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign sample_data   = r.sample;
  assign sample_valid  = r.sample_valid;

  logic [1:0] cq_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cq_q <= CQ_ANY;
    else cq_q <= (next_r.speed == SPD_HIGH) ? CQ_NONE :
                 (next_r.speed == SPD_FAST) ? CQ_STATE : CQ_ANY;
  end
  assign count_qual_mode = cq_q;

  property p_slave_first;
    @(posedge ref_clk) disable iff (!resetn)
    (r.slv_got0 && !master) |=> (r.slv_lat0 == $past(r.slv_lat0));
  endproperty
  a_slave_first: assert property (p_slave_first) else $error("slave latch overwritten");

  property p_rearm;
    @(posedge ref_clk) disable iff (!resetn)
    (master && !(|slv_hit0) && !(|slv_hit1)) |=> !r.slv_got0 && !r.slv_got1;
  endproperty
  a_rearm: assert property (p_rearm) else $error("slave latch not rearmed");

  sequence s_cap;
    master ##1 sample_valid;
  endsequence
  property p_cap;
    @(posedge ref_clk) disable iff (!resetn)
    master |-> s_cap;
  endproperty
  a_cap: assert property (p_cap) else $error("capture not flagged");

  property p_rate;
    @(posedge ref_clk) disable iff (!resetn)
    (sample_valid && r.speed == SPD_SLOW) |=> !sample_valid;
  endproperty
  a_rate: assert property (p_rate) else $error("rate cap exceeded");

  property p_cq;
    @(posedge ref_clk) disable iff (!resetn)
    (r.speed == SPD_HIGH) [*2] |-> count_qual_mode == CQ_NONE;
  endproperty
  a_cq: assert property (p_cq) else $error("count qualifier not disabled");

  property p_demux;
    @(posedge ref_clk) disable iff (!resetn)
    (master && r.slv_mode0 == SLV_DEMUX && !r.slv_got0) |=>
      sample_data[7:0] == sample_data[15:8];
  endproperty
  a_demux: assert property (p_demux) else $error("demux low byte differs");

  property p_qual;
    @(posedge ref_clk) disable iff (!resetn)
    (master && r.fgbg == 2'h0 && r.qual_lo == '0 && r.qual_hi != '0) |-> |qual_ok;
  endproperty
  a_qual: assert property (p_qual) else $error("unqualified clock passed");

  property p_mixed;
    @(posedge ref_clk) disable iff (!resetn)
    (master && r.slv_mode0 == SLV_MIXED && r.slv_got0) |=>
      sample_data[7:0] == $past(r.slv_lat0);
  endproperty
  a_mixed: assert property (p_mixed) else $error("mixed low byte not slave data");

  property p_mixed_live;
    @(posedge ref_clk) disable iff (!resetn)
    (master && r.slv_mode0 == SLV_MIXED && !r.slv_got0) |=>
      sample_data[7:0] == $past(r.ch_s2[7:0]);
  endproperty
  a_mixed_live: assert property (p_mixed_live) else $error("mixed low byte not live");

  property p_demux_up;
    @(posedge ref_clk) disable iff (!resetn)
    (master && r.slv_mode0 == SLV_DEMUX) |=> sample_data[15:8] == $past(r.ch_s2[7:0]);
  endproperty
  a_demux_up: assert property (p_demux_up) else $error("demux upper byte wrong");

  property p_slave_first1;
    @(posedge ref_clk) disable iff (!resetn)
    (r.slv_got1 && !master) |=> (r.slv_lat1 == $past(r.slv_lat1));
  endproperty
  a_slave_first1: assert property (p_slave_first1) else $error("pod two latch overwritten");

  property p_slave_off1;
    @(posedge ref_clk) disable iff (!resetn)
    (master && r.slv_mode1 == SLV_OFF) |=> sample_data[23:16] == $past(r.ch_s2[23:16]);
  endproperty
  a_slave_off1: assert property (p_slave_off1) else $error("pod two low byte not live");

  property p_fgbg;
    @(posedge ref_clk) disable iff (!resetn)
    (master && r.qual_lo == '0 && r.qual_hi == '0 && r.fgbg != 2'h0) |-> fgbg_ok;
  endproperty
  a_fgbg: assert property (p_fgbg) else $error("clock passed outside fg/bg choice");

  sequence s_quiet2;
    !sample_valid ##1 !sample_valid;
  endsequence
  property p_rate_slow;
    @(posedge ref_clk) disable iff (!resetn)
    (sample_valid && $past(r.speed) == SPD_SLOW) |=> s_quiet2;
  endproperty
  a_rate_slow: assert property (p_rate_slow) else $error("slow grade spacing too short");

  property p_cq_fast;
    @(posedge ref_clk) disable iff (!resetn)
    (r.speed == SPD_FAST) [*2] |-> count_qual_mode == CQ_STATE;
  endproperty
  a_cq_fast: assert property (p_cq_fast) else $error("count qualifier not states only");

  property p_cq_slow;
    @(posedge ref_clk) disable iff (!resetn)
    (r.speed == SPD_SLOW) [*2] |-> count_qual_mode == CQ_ANY;
  endproperty
  a_cq_slow: assert property (p_cq_slow) else $error("count qualifier restricted");
endmodule

//--- testbench/tcdf_probe_model.sv
// target-side model: five clock lines and the thirty-two trace channels
`timescale 1ns/1ps
module tcdf_probe_model
  import tcdf_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic [NUM_LINES-1:0] line_tgl,
  input  wire logic [CH_W-1:0]      ch_set,
  input  wire logic [CH_W-1:0]      wig,
  output logic      [NUM_LINES-1:0] clk_line,
  output logic      [CH_W-1:0]      trace_ch
);
  logic flip;

  initial begin
    clk_line = '0;
    trace_ch = '0;
    flip     = 1'h0;
  end

  // lines move only on request; wiggled channels change every cycle
  always @(posedge ref_clk) begin
    flip     <= ~flip;
    clk_line <= clk_line ^ line_tgl;
    trace_ch <= ch_set ^ (flip ? wig : '0);
  end
endmodule

//--- testbench/tcdf_frontend_bench.sv
// self-checking bench of the trace clock demux front end
`timescale 1ns/1ps
module tcdf_frontend_bench
  import tcdf_pkg::*;
;
  logic                 ref_clk;
  logic                 resetn;
  logic [NUM_LINES-1:0] line_tgl;
  logic [CH_W-1:0]      ch_set;
  logic [CH_W-1:0]      wig;
  logic [NUM_LINES-1:0] clk_line;
  logic [CH_W-1:0]      trace_ch;
  logic [7:0]           awaddr;
  logic                 awvalid;
  logic                 awready;
  logic [31:0]          wdata;
  logic                 wvalid;
  logic                 wready;
  logic [1:0]           bresp;
  logic                 bvalid;
  logic                 bready;
  logic [7:0]           araddr;
  logic                 arvalid;
  logic                 arready;
  logic [31:0]          rdata;
  logic [1:0]           rresp;
  logic                 rvalid;
  logic                 rready;
  logic [CH_W-1:0]      sample_data;
  logic                 sample_valid;
  logic [1:0]           count_qual_mode;
  int                   err_count;
  int                   checks;
  int                   nsmp;
  int                   n0;
  logic [31:0]          va;
  logic [31:0]          vc;
  logic [1:0]           cq [3];

  tcdf_probe_model probe (.ref_clk(ref_clk), .line_tgl(line_tgl), .ch_set(ch_set), .wig(wig),
    .clk_line(clk_line), .trace_ch(trace_ch));

  tcdf_frontend dut (.ref_clk(ref_clk), .resetn(resetn), .clk_line(clk_line),
    .trace_ch(trace_ch), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_data(sample_data), .sample_valid(sample_valid), .count_qual_mode(count_qual_mode));

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (sample_valid === 1'h1) nsmp <= nsmp + 1;
  end

  task automatic conclude;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 50);
    check({bvalid, bresp}, {1'h1, er});
    bready <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 50);
    check({rvalid, rresp}, {1'h1, er});
    check(rdata, ed);
    rready  <= 1'h0;
    @(posedge ref_clk);
  endtask

  // toggle the masked lines once and count the samples that follow
  task automatic pulse(input logic [4:0] m, input int n);
    int s;
    s = nsmp;
    line_tgl <= m;
    @(posedge ref_clk);
    line_tgl <= '0;
    repeat (8) @(posedge ref_clk);
    check(nsmp - s, n);
  endtask

  function automatic logic [31:0] act_exp(input logic [31:0] v, input int mv, input int b);
    logic [31:0] e;
    for (int i = 0; i < 16; i++) begin
      e[2*i+:2] = (b + i == mv) ? ACT_MOVE : (v[b+i] ? ACT_HIGH : ACT_LOW);
    end
    return e;
  endfunction

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, line_tgl, ch_set, wig} = '0;
    {err_count, checks, nsmp} = '0;
    cq = '{CQ_ANY, CQ_STATE, CQ_NONE};
    va = 32'h1234_56a7;
    vc = 32'hbeef_cafe;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    rdc(ADDR_MEDGE, {22'h0, RST_MEDGE}, RESP_OKAY);
    rdc(ADDR_QUAL, {20'h0, RST_FGBG, 10'h0}, RESP_OKAY);
    rdc(ADDR_SPEED, 32'h0, RESP_OKAY);
    rdc(ADDR_SLAVE, 32'h0, RESP_OKAY);
    check(count_qual_mode, CQ_ANY);
    ch_set <= 32'hc3a5_5a3c;
    pulse(5'h04, 1);
    check(sample_data, 32'hc3a5_5a3c);
    pulse(5'h04, 0);
    wrc(ADDR_MEDGE, 32'h30, RESP_OKAY);
    pulse(5'h04, 1);
    pulse(5'h04, 1);
    wrc(ADDR_MEDGE, 32'h20, RESP_OKAY);
    pulse(5'h04, 0);
    pulse(5'h04, 1);
    wrc(ADDR_MEDGE, 32'h50, RESP_OKAY);
    pulse(5'h04, 1);
    pulse(5'h08, 1);
    pulse(5'h0c, 0);
    pulse(5'h10, 0);
    pulse(5'h04, 0);
    pulse(5'h04, 0);
    wrc(ADDR_QUAL, 32'h800, RESP_OKAY);
    rdc(ADDR_MEDGE, 32'h50, RESP_OKAY);
    pulse(5'h04, 1);
    pulse(5'h04, 0);
    wrc(ADDR_QUAL, 32'hc00, RESP_OKAY);
    pulse(5'h04, 1);
    pulse(5'h04, 0);
    pulse(5'h10, 0);
    pulse(5'h04, 1);
    pulse(5'h04, 0);
    // external line as the only qualifier, fg/bg off
    wrc(ADDR_QUAL, 32'h020, RESP_OKAY);
    pulse(5'h04, 0);
    pulse(5'h04, 0);
    pulse(5'h01, 0);
    pulse(5'h04, 1);
    pulse(5'h04, 0);
    wrc(ADDR_QUAL, 32'h420, RESP_OKAY);
    pulse(5'h01, 0);
    pulse(5'h04, 1);
    pulse(5'h04, 0);
    pulse(5'h10, 0);
    pulse(5'h04, 0);
    pulse(5'h04, 0);
    pulse(5'h10, 0);
    wrc(ADDR_QUAL, 32'h002, RESP_OKAY);
    pulse(5'h04, 1);
    pulse(5'h04, 0);
    wrc(ADDR_MEDGE, 32'h30, RESP_OKAY);
    for (int s = 0; s < 3; s++) begin
      wrc(ADDR_SPEED, s, RESP_OKAY);
      check(count_qual_mode, cq[s]);
      n0 = nsmp;
      line_tgl <= 5'h04;
      repeat (12) @(posedge ref_clk);
      line_tgl <= '0;
      repeat (10) @(posedge ref_clk);
      check(nsmp - n0, s == 0 ? (12 + GAP_SLOW - 1) / GAP_SLOW : s == 1 ? 6 :
        (12 + GAP_HIGH - 1) / GAP_HIGH);
    end
    wrc(ADDR_SPEED, 32'h0, RESP_OKAY);
    rdc(ADDR_STATUS, 32'(30 - (12 + GAP_SLOW - 1) / GAP_SLOW -
      (12 + GAP_HIGH - 1) / GAP_HIGH), RESP_OKAY);
    wrc(ADDR_QUAL, 32'h400, RESP_OKAY);
    wrc(ADDR_MEDGE, 32'h10, RESP_OKAY);
    wrc(ADDR_SLAVE, 32'h101, RESP_OKAY);
    ch_set <= va;
    pulse(5'h08, 0);
    ch_set <= 32'h0000_00ff;
    pulse(5'h08, 0);
    pulse(5'h08, 0);
    ch_set <= vc;
    pulse(5'h04, 1);
    check(sample_data, {vc[31:8], va[7:0]});
    pulse(5'h04, 0);
    pulse(5'h04, 1);
    check(sample_data, vc);
    pulse(5'h04, 0);
    pulse(5'h08, 0);
    wrc(ADDR_SLAVE, 32'h102, RESP_OKAY);
    ch_set <= va;
    pulse(5'h08, 0);
    ch_set <= vc;
    pulse(5'h04, 1);
    check(sample_data, {vc[31:16], vc[7:0], va[7:0]});
    pulse(5'h04, 0);
    pulse(5'h04, 1);
    check(sample_data, {vc[31:16], vc[7:0], vc[7:0]});
    pulse(5'h04, 0);
    pulse(5'h08, 0);
    wrc(ADDR_SLAVE, 32'h10_1000, RESP_OKAY);
    ch_set <= va;
    pulse(5'h08, 0);
    ch_set <= vc;
    pulse(5'h04, 1);
    check(sample_data, {vc[31:24], va[23:16], vc[15:0]});
    pulse(5'h04, 0);
    ch_set <= 32'h0f0f_3c3c;
    repeat (600) @(posedge ref_clk);
    rdc(ADDR_ACT_LO, act_exp(32'h0f0f_3c3c, -1, 0), RESP_OKAY);
    rdc(ADDR_ACT_HI, act_exp(32'h0f0f_3c3c, -1, 16), RESP_OKAY);
    rdc(ADDR_LIVE, 32'h0f0f_3c3c, RESP_OKAY);
    wig <= 32'h0000_0020;
    repeat (600) @(posedge ref_clk);
    rdc(ADDR_ACT_LO, act_exp(32'h0f0f_3c3c, 5, 0), RESP_OKAY);
    wig <= '0;
    wrc(ADDR_SAMPLE, 32'h1, RESP_SLVERR);
    rdc(8'h40, 32'h0, RESP_SLVERR);
    wrc(8'h40, 32'h1, RESP_SLVERR);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
endmodule
